// File: pps_cfg.svh
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH

// Clock and timebase
`define PPS_CLK_NS        25
`define PPS_TICK_NS       100000
`define PPS_TICK_CYC      (`PPS_TICK_NS / `PPS_CLK_NS)

// Speed timing, times in microseconds
`define PPS_GATE0_US      800
`define PPS_GATE0_TICKS   ((`PPS_GATE0_US * 1000) / `PPS_TICK_NS)
`define PPS_ROT_UPD_US    117200
`define PPS_ROT_TICKS     ((`PPS_ROT_UPD_US * 1000) / `PPS_TICK_NS)
`define PPS_ROT_WIN_US    234400
`define PPS_ROT_LAG       (`PPS_ROT_WIN_US / `PPS_ROT_UPD_US)
`define PPS_TRV_UPD_US    200000
`define PPS_TRV_TICKS     ((`PPS_TRV_UPD_US * 1000) / `PPS_TICK_NS)
`define PPS_TRV_WIN_US    1000000
`define PPS_TRV_LAG       (`PPS_TRV_WIN_US / `PPS_TRV_UPD_US)
`define PPS_HIST_DEPTH    5

// Rotation scaling: counts over the window times NUM, shifted right
`define PPS_RPM_NUM       48'h1
`define PPS_RPM_SHIFT     4

// Codes
`define PPS_ERR_SENSOR    8'h16
`define PPS_CODE_ROT      16'h0007
`define PPS_CODE_TRV      16'h0008
`define PPS_CODE_GMAX     16'h0006

// Word addresses
`define PPS_A_INSTAT      10'h006
`define PPS_A_SPD_L       10'h29c
`define PPS_A_SPD_H       10'h29d
`define PPS_A_HSC_L       10'h29e
`define PPS_A_HSC_H       10'h29f
`define PPS_A_HRW_L       10'h2a0
`define PPS_A_HRW_H       10'h2a1
`define PPS_A_PV1_L       10'h2b2
`define PPS_A_PV1_H       10'h2b3
`define PPS_A_PV2_L       10'h2b4
`define PPS_A_PV2_H       10'h2b5
`define PPS_A_MODE        10'h2ec
`define PPS_A_GATE        10'h2ed
`define PPS_A_SAMP        10'h2ee

// Reset values
`define PPS_RST_MODE      16'h0000
`define PPS_RST_GATE      16'h0000
`define PPS_RST_SAMP      16'h0000
`define PPS_RST_PV        32'h0000_0000

`endif

// File: pps_pkg.sv
package pps_pkg;
  typedef enum logic [1:0] {
    PPS_MODE_OFF,
    PPS_MODE_PARAM,
    PPS_MODE_BUF,
    PPS_MODE_SEQ
  } pps_mode_t;

  typedef enum logic [1:0] {
    PPS_KIND_GATE,
    PPS_KIND_ROT,
    PPS_KIND_TRV,
    PPS_KIND_NONE
  } pps_kind_t;
endpackage

// File: pps_edge.sv
`timescale 1ns/1ps
module pps_edge (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);
  logic       sync1_reg;
  logic       sync2_reg;
  logic       prev_reg;
  logic [1:0] prime_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
      prime_reg <= 2'h0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
      if (prime_reg != 2'h3) begin
        prime_reg <= prime_reg + 2'h1;
      end
    end
  end

  // A level already high when the pipe fills gives no edge
  assign level = sync2_reg;
  assign rise  = (prime_reg == 2'h3) && sync2_reg && !prev_reg;
endmodule

// File: pps_top.sv
`timescale 1ns/1ps
`include "pps_cfg.svh"
module pps_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        preset_in1_pin,
  input  wire logic        preset_in2_pin,
  input  wire logic        online_request,
  input  wire logic        preset_block_one_or_command,
  input  wire logic        preset_block_two,
  input  wire logic [7:0]  sensor_error_code,
  input  wire logic        sensor_dir_pos,
  input  wire logic [31:0] scaled_pos,
  input  wire logic [31:0] raw_pos,
  input  wire logic [31:0] param_preset1,
  input  wire logic [31:0] param_preset2,
  input  wire logic [9:0]  host_addr,
  input  wire logic [15:0] host_wdata,
  input  wire logic        host_buffer_write,
  input  wire logic        host_rd,
  output logic      [15:0] host_rdata,
  output logic             online_flag,
  output logic             pos_load,
  output logic      [31:0] pos_load_value
);
  localparam int TICK_MAX = `PPS_TICK_CYC - 1;

  logic        lvl1;
  logic        lvl2;
  logic        rise1;
  logic        rise2;
  logic [15:0] mode_reg;
  logic [15:0] gate_reg;
  logic [15:0] samp_reg;
  logic [31:0] pv1_reg;
  logic [31:0] pv2_reg;
  logic        online_reg;
  logic        cmd_prev_reg;
  logic        load_reg;
  logic [31:0] load_val_reg;
  logic [31:0] hold_sc_reg;
  logic [31:0] hold_raw_reg;
  logic [31:0] spd_reg;
  logic [15:0] shadow_spd_reg;
  logic [15:0] shadow_sc_reg;
  logic [15:0] shadow_raw_reg;
  logic [15:0] rdata_reg;
  logic [11:0] tick_cnt_reg;
  logic        tick_reg;
  logic [10:0] per_cnt_reg;
  logic        sample_reg;
  logic [31:0] hist_reg [`PPS_HIST_DEPTH];

  pps_edge u_in1 (
    .clk   (clk),
    .reset (reset),
    .pin   (preset_in1_pin),
    .level (lvl1),
    .rise  (rise1)
  );

  pps_edge u_in2 (
    .clk   (clk),
    .reset (reset),
    .pin   (preset_in2_pin),
    .level (lvl2),
    .rise  (rise2)
  );

  // Preset qualification
  pps_pkg::pps_mode_t mode;
  logic               mode_ok;
  logic               preset_ok;
  logic               cmd_rise;
  logic               ext1;
  logic               ext2;

  always_comb begin
    mode    = pps_pkg::pps_mode_t'(mode_reg[1:0]);
    mode_ok = (mode_reg[15:2] == 14'h0) && (mode != pps_pkg::PPS_MODE_OFF);
    preset_ok = mode_ok && online_reg
      && (sensor_error_code != `PPS_ERR_SENSOR);
    cmd_rise = preset_block_one_or_command && !cmd_prev_reg;
    ext1 = rise1 && !preset_block_one_or_command;
    ext2 = rise2 && !preset_block_two && !rise1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      online_reg <= 1'b0;
    end else begin
      online_reg <= online_request;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_prev_reg <= 1'b0;
    end else begin
      cmd_prev_reg <= preset_block_one_or_command;
    end
  end

  // Load issues one cycle after the edge, far inside the response limits
  always_ff @(posedge clk) begin
    if (reset) begin
      load_reg     <= 1'b0;
      load_val_reg <= 32'h0;
    end else begin
      load_reg <= 1'b0;
      if (preset_ok) begin
        case (mode)
          pps_pkg::PPS_MODE_SEQ: begin
            if (cmd_rise) begin
              load_reg     <= 1'b1;
              load_val_reg <= pv1_reg;
            end
          end
          pps_pkg::PPS_MODE_PARAM,
          pps_pkg::PPS_MODE_BUF: begin
            if (ext1) begin
              load_reg     <= 1'b1;
              load_val_reg <= (mode == pps_pkg::PPS_MODE_PARAM) ? param_preset1 : pv1_reg;
            end else if (ext2) begin
              load_reg     <= 1'b1;
              load_val_reg <= (mode == pps_pkg::PPS_MODE_PARAM) ? param_preset2 : pv2_reg;
            end
          end
          default: begin
            load_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // Hold samples the inputs in the edge cycle, before any load lands
  always_ff @(posedge clk) begin
    if (reset) begin
      hold_sc_reg  <= 32'h0;
      hold_raw_reg <= 32'h0;
    end else if (rise1 || rise2) begin
      hold_sc_reg  <= scaled_pos;
      hold_raw_reg <= raw_pos;
    end
  end

  // Register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_reg <= `PPS_RST_MODE;
      gate_reg <= `PPS_RST_GATE;
      samp_reg <= `PPS_RST_SAMP;
      pv1_reg  <= `PPS_RST_PV;
      pv2_reg  <= `PPS_RST_PV;
    end else if (host_buffer_write) begin
      case (host_addr)
        `PPS_A_MODE:  mode_reg <= host_wdata;
        `PPS_A_GATE:  gate_reg <= host_wdata;
        `PPS_A_SAMP:  samp_reg <= host_wdata;
        // New values apply at once; the host still keeps its settle time
        `PPS_A_PV1_L: pv1_reg[15:0]  <= host_wdata;
        `PPS_A_PV1_H: pv1_reg[31:16] <= host_wdata;
        `PPS_A_PV2_L: pv2_reg[15:0]  <= host_wdata;
        `PPS_A_PV2_H: pv2_reg[31:16] <= host_wdata;
        default: begin
          mode_reg <= mode_reg;
        end
      endcase
    end
  end

  // Reads; a speed or hold low-word read freezes its high word for the next read
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg      <= 16'h0;
      shadow_spd_reg <= 16'h0;
      shadow_sc_reg  <= 16'h0;
      shadow_raw_reg <= 16'h0;
    end else if (host_rd) begin
      case (host_addr)
        `PPS_A_INSTAT: rdata_reg <= {14'h0, lvl2, lvl1};
        `PPS_A_SPD_L: begin
          rdata_reg      <= spd_reg[15:0];
          shadow_spd_reg <= spd_reg[31:16];
        end
        `PPS_A_SPD_H:  rdata_reg <= shadow_spd_reg;
        `PPS_A_HSC_L: begin
          rdata_reg     <= hold_sc_reg[15:0];
          shadow_sc_reg <= hold_sc_reg[31:16];
        end
        `PPS_A_HSC_H:  rdata_reg <= shadow_sc_reg;
        `PPS_A_HRW_L: begin
          rdata_reg      <= hold_raw_reg[15:0];
          shadow_raw_reg <= hold_raw_reg[31:16];
        end
        `PPS_A_HRW_H:  rdata_reg <= shadow_raw_reg;
        `PPS_A_PV1_L:  rdata_reg <= pv1_reg[15:0];
        `PPS_A_PV1_H:  rdata_reg <= pv1_reg[31:16];
        `PPS_A_PV2_L:  rdata_reg <= pv2_reg[15:0];
        `PPS_A_PV2_H:  rdata_reg <= pv2_reg[31:16];
        `PPS_A_MODE:   rdata_reg <= mode_reg;
        `PPS_A_GATE:   rdata_reg <= gate_reg;
        `PPS_A_SAMP:   rdata_reg <= samp_reg;
        default:       rdata_reg <= 16'h0;
      endcase
    end
  end

  // Speed kind and sample period in 0.1 ms ticks
  pps_pkg::pps_kind_t kind;
  logic [10:0]        samp_per;
  logic [2:0]         lag_idx;
  logic [1:0]         samp_sh;

  always_comb begin
    samp_sh  = (samp_reg > 16'h2) ? 2'h0 : samp_reg[1:0];
    kind     = pps_pkg::PPS_KIND_NONE;
    samp_per = 11'(`PPS_TRV_TICKS);
    lag_idx  = 3'h0;
    if (gate_reg <= `PPS_CODE_GMAX) begin
      kind     = pps_pkg::PPS_KIND_GATE;
      samp_per = 11'((`PPS_GATE0_TICKS << gate_reg[2:0]) >> samp_sh);
      lag_idx  = 3'((1 << samp_sh) - 1);
    end else if (gate_reg == `PPS_CODE_ROT) begin
      kind     = pps_pkg::PPS_KIND_ROT;
      samp_per = 11'(`PPS_ROT_TICKS);
      lag_idx  = 3'(`PPS_ROT_LAG - 1);
    end else if (gate_reg == `PPS_CODE_TRV) begin
      kind     = pps_pkg::PPS_KIND_TRV;
      samp_per = 11'(`PPS_TRV_TICKS);
      lag_idx  = 3'(`PPS_TRV_LAG - 1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tick_cnt_reg <= 12'h0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 12'(TICK_MAX)) begin
      tick_cnt_reg <= 12'h0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 12'h1;
      tick_reg     <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      per_cnt_reg <= 11'h0;
      sample_reg  <= 1'b0;
    end else begin
      sample_reg <= 1'b0;
      if (tick_reg) begin
        if (per_cnt_reg >= samp_per - 11'h1) begin
          per_cnt_reg <= 11'h0;
          sample_reg  <= 1'b1;
        end else begin
          per_cnt_reg <= per_cnt_reg + 11'h1;
        end
      end
    end
  end

  // Change over the window against the sample lag_idx+1 steps back
  logic [31:0]        cur;
  logic signed [31:0] diff;
  logic signed [47:0] sdiff;
  logic signed [47:0] scaled;
  logic [31:0]        mag32;
  logic [47:0]        mag48;
  logic [15:0]        sat_s;
  logic [15:0]        sat_u;

  always_comb begin
    cur   = (kind == pps_pkg::PPS_KIND_TRV) ? scaled_pos : raw_pos;
    diff  = $signed(cur - hist_reg[lag_idx]);
    mag32 = diff[31] ? 32'(-diff) : 32'(diff);
    sdiff = sensor_dir_pos ? 48'(diff) : -48'(diff);
    if (kind == pps_pkg::PPS_KIND_ROT) begin
      scaled = (sdiff * $signed(`PPS_RPM_NUM)) >>> `PPS_RPM_SHIFT;
    end else begin
      scaled = sdiff;
    end
    mag48 = scaled[47] ? 48'(-scaled) : 48'(scaled);
    if (scaled > 48'sd32767) begin
      sat_s = 16'h7fff;
    end else if (scaled < -48'sd32768) begin
      sat_s = 16'h8000;
    end else begin
      sat_s = scaled[15:0];
    end
    sat_u = (mag48 > 48'hffff) ? 16'hffff : mag48[15:0];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `PPS_HIST_DEPTH; i++) begin
        hist_reg[i] <= 32'h0;
      end
    end else if (sample_reg) begin
      hist_reg[0] <= cur;
      for (int i = 1; i < `PPS_HIST_DEPTH; i++) begin
        hist_reg[i] <= hist_reg[i-1];
      end
    end
  end

  // Whole word updates at once, so a pair read never mixes samples
  always_ff @(posedge clk) begin
    if (reset) begin
      spd_reg <= 32'h0;
    end else if (sample_reg) begin
      case (kind)
        pps_pkg::PPS_KIND_GATE: spd_reg <= mag32;
        pps_pkg::PPS_KIND_ROT,
        pps_pkg::PPS_KIND_TRV:  spd_reg <= {sat_u, sat_s};
        default:                spd_reg <= spd_reg;
      endcase
    end
  end

  assign host_rdata     = rdata_reg;
  assign online_flag    = online_reg;
  assign pos_load       = load_reg;
  assign pos_load_value = load_val_reg;
endmodule

// File: pps_monitor.sv
`timescale 1ns/1ps
module pps_monitor (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        preset_in1_pin,
  input wire logic        preset_in2_pin,
  input wire logic        online_request,
  input wire logic        preset_block_one_or_command,
  input wire logic [7:0]  sensor_error_code,
  input wire logic [9:0]  host_addr,
  input wire logic        host_rd,
  input wire logic [15:0] host_rdata,
  input wire logic        online_flag,
  input wire logic        pos_load,
  input wire logic [31:0] pos_load_value
);
  logic [6:0] h1_reg;
  logic [6:0] h2_reg;
  logic [3:0] hb_reg;
  logic [2:0] st_reg;
  wire        pin_rise = (|(h1_reg[5:2] & ~h1_reg[6:3])) | (|(h2_reg[5:2] & ~h2_reg[6:3]));
  wire        cmd_rise = |(hb_reg[2:0] & ~hb_reg[3:1]);
  // Histories are not reset: a stale rise only widens what counts as a cause
  always_ff @(posedge clk) begin
    h1_reg <= {h1_reg[5:0], preset_in1_pin};
    h2_reg <= {h2_reg[5:0], preset_in2_pin};
    hb_reg <= {hb_reg[2:0], preset_block_one_or_command};
  end
  always_ff @(posedge clk) begin
    if (reset || preset_in1_pin != h1_reg[0] || preset_in2_pin != h2_reg[0]) begin
      st_reg <= 3'h0;
    end else if (st_reg != 3'h7) begin
      st_reg <= st_reg + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_load_one_cycle: assert property (pos_load |=> !pos_load)
    else $error("load pulse longer than one cycle");
  a_load_has_cause: assert property (pos_load |-> pin_rise || cmd_rise)
    else $error("load without a rising input");
  a_load_needs_online: assert property (pos_load |-> $past(online_flag))
    else $error("load while offline");
  a_load_no_fault: assert property (pos_load |-> $past(sensor_error_code) != 8'h16)
    else $error("load during sensor fault");
  a_value_with_load: assert property ($changed(pos_load_value) |-> pos_load)
    else $error("load value moved without a load");
  a_rdata_holds: assert property (!host_rd |=> $stable(host_rdata))
    else $error("read data changed without a read");
  a_instat_mirror: assert property (host_rd && host_addr == 10'h006 && st_reg == 3'h7
    |=> host_rdata[1:0] == $past({preset_in2_pin, preset_in1_pin}))
    else $error("input status differs from pins");
  a_online_follows: assert property (online_request [*2] |-> online_flag)
    else $error("online flag not raised");
  c_load: cover property (pos_load);
  c_speed_read: cover property (host_rd && host_addr == 10'h29c);
  c_pin_steady: cover property (st_reg == 3'h7 && preset_in1_pin);
endmodule
bind pps_top pps_monitor i_pps_monitor (.clk, .reset, .preset_in1_pin, .preset_in2_pin,
  .online_request, .preset_block_one_or_command, .sensor_error_code, .host_addr, .host_rd,
  .host_rdata, .online_flag, .pos_load, .pos_load_value);

// File: pps_switch_model.sv
`timescale 1ns/1ps
module pps_switch_model #(
  parameter int HOLD_CYC = 40
) (
  input  wire logic       clk,
  input  wire logic [1:0] fire,
  output logic            pin1,
  output logic            pin2
);
  int cnt = 0;
  initial {pin2, pin1} = 2'h0;
  // A press is ignored until both on and off times have run out
  always @(negedge clk) begin
    if (cnt == 0 && fire != 2'h0) begin
      {pin2, pin1} <= fire;
      cnt <= 2 * HOLD_CYC;
    end else if (cnt != 0) begin
      if (cnt == HOLD_CYC + 1) begin
        {pin2, pin1} <= 2'h0;
      end
      cnt <= cnt - 1;
    end
  end
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int HOLD = 40;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        online_request = 1'b1;
  logic        b1 = 1'b0;
  logic        b2 = 1'b0;
  logic [7:0]  err = 8'h00;
  logic [31:0] spos = 32'h0, rpos = 32'h0, pp1 = 32'h0, pp2 = 32'h0;
  logic [9:0]  addr = 10'h0;
  logic [15:0] wdata = 16'h0, rdata;
  logic        wr_en = 1'b0, rd_en = 1'b0, online_flag, pos_load, pin1, pin2;
  logic [31:0] load_val, dstep = 32'h0;
  logic [1:0]  fire = 2'h1;
  logic        ramp = 1'b0;
  logic        dn = 1'b0, dir = 1'b1;
  int          fails = 0, samples_checked = 0, loads = 0, rcnt = 0;
  always #12.5 clk = ~clk;
  // Counted away from the launching edge, where the pulse has settled
  always @(negedge clk) if (pos_load === 1'b1) loads++;
  // Stand-in for the position logic, so a hold must catch the value before the load
  always @(negedge clk) if (pos_load === 1'b1) spos = load_val;
  always @(negedge clk) begin
    if (ramp) begin
      rcnt++;
      if (rcnt % 1000 == 0) rpos = dn ? rpos - dstep : rpos + dstep;
    end
  end
  pps_top i_pps_top (.clk(clk), .reset(reset), .preset_in1_pin(pin1), .preset_in2_pin(pin2),
    .online_request(online_request), .preset_block_one_or_command(b1), .preset_block_two(b2),
    .sensor_error_code(err), .sensor_dir_pos(dir), .scaled_pos(spos), .raw_pos(rpos),
    .param_preset1(pp1), .param_preset2(pp2), .host_addr(addr), .host_wdata(wdata),
    .host_buffer_write(wr_en), .host_rd(rd_en), .host_rdata(rdata),
    .online_flag(online_flag), .pos_load(pos_load), .pos_load_value(load_val));
  pps_switch_model #(.HOLD_CYC(HOLD)) i_pps_switch_model (.clk(clk), .fire(fire),
    .pin1(pin1), .pin2(pin2));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    d = {16'h0, rdata};
  endtask
  // Low word first, so the high half comes from the same sample
  task automatic rd32(input logic [9:0] a, output logic [31:0] d);
    logic [31:0] lo;
    logic [31:0] hi;
    rd(a, lo);
    rd(a + 10'h1, hi);
    d = {hi[15:0], lo[15:0]};
  endtask
  task automatic press(input logic [1:0] f);
    logic [31:0] w;
    @(negedge clk);
    fire <= f;
    @(negedge clk);
    fire <= 2'h0;
    cyc(HOLD / 2);
    rd(10'h006, w);
    check(w, {30'h0, f});
    cyc(2 * HOLD);
  endtask
  function automatic logic [1:0] pick(input int m, input logic on, input logic [7:0] e,
                                      input logic [1:0] bl, input logic [1:0] f);
    if (!on || e == 8'h16 || m == 0 || m == 3) return 2'h0;
    if (f[0]) return bl[0] ? 2'h0 : 2'h1;
    return bl[1] ? 2'h0 : 2'h2;
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #2500000;
    fails++;
    report_and_stop;
  end
  initial begin
    logic [31:0] v, bv1, bv2, old_s, old_r;
    logic [1:0]  sel, f;
    int          m, base;
    void'($urandom(13));
    @(negedge clk);
    fire <= 2'h0;
    cyc(3);
    reset = 1'b0;
    rd(10'h2ec, v);
    check(v, 32'h0);
    rd(10'h2ed, v);
    check(v, 32'h0);
    rd(10'h2ee, v);
    check(v, 32'h0);
    wr(10'h2ec, 16'h0001);
    cyc(2 * HOLD);
    check(loads, 0);
    rd32(10'h29e, v);
    check(v, 32'h0);
    rd(10'h3ff, v);
    check(v, 32'h0);
    wr(10'h2a0, 16'h1234);
    rd(10'h2a0, v);
    check(v, 32'h0);
    $display("test power_up done");
    for (int i = 0; i < 16; i++) begin
      m = i % 4;
      wr(10'h2ec, 16'(m));
      pp1 = $urandom;
      pp2 = $urandom;
      bv1 = $urandom;
      bv2 = $urandom;
      wr(10'h2b2, bv1[15:0]);
      wr(10'h2b3, bv1[31:16]);
      wr(10'h2b4, bv2[15:0]);
      wr(10'h2b5, bv2[31:16]);
      {b2, b1} = (i < 4) ? 2'h0 : 2'($urandom);
      online_request = (i % 7 != 5);
      err = ($urandom % 3 == 0) ? 8'h16 : 8'h00;
      spos = $urandom;
      rpos = $urandom;
      cyc(8);
      check(online_flag, online_request);
      base = loads;
      old_s = spos;
      old_r = rpos;
      f = (i % 4 == 1) ? 2'h3 : 2'($urandom % 3 + 1);
      press(f);
      sel = pick(m, online_request, err, {b2, b1}, f);
      check(loads - base, sel != 2'h0);
      if (sel != 2'h0) begin
        check(load_val, m == 1 ? (sel == 2'h1 ? pp1 : pp2) : (sel == 2'h1 ? bv1 : bv2));
      end
      rd32(10'h29e, v);
      check(v, old_s);
      rd32(10'h2a0, v);
      check(v, old_r);
      if (m == 3) begin
        b1 = 1'b0;
        cyc(4);
        base = loads;
        b1 = 1'b1;
        cyc(10);
        check(loads - base, online_request && err != 8'h16);
        if (loads != base) check(load_val, bv1);
      end
      $display("test preset %0d mode %0d done", i, m);
    end
    err = 8'h00;
    v = $urandom % 3;
    wr(10'h2ee, v[15:0]);
    dstep = $urandom % 1000 + 1;
    dn = 1'($urandom);
    dir = 1'($urandom);
    ramp = 1'b1;
    // Every sampling choice spans one gate of 32000 cycles, so 32 steps either way
    cyc(66000);
    rd32(10'h29c, v);
    check(v, 32 * dstep);
    $display("test speed done");
    report_and_stop;
  end
endmodule
